// [rtl/cascaded_pic_pkg.sv]
// Shared constants and types for the cascaded interrupt controller pair.
// Assumes one clock domain and byte-wide register accesses.
package cascaded_pic_pkg;

	// ----------------------------------------
	// Register addresses
	// ----------------------------------------
	localparam logic [7:0] ADDR_MASTER_EVEN = 8'h20;
	localparam logic [7:0] ADDR_MASTER_ODD  = 8'h21;
	localparam logic [7:0] ADDR_SLAVE_EVEN  = 8'hA0;
	localparam logic [7:0] ADDR_SLAVE_ODD   = 8'hA1;
	localparam logic [7:0] ADDR_EVT_STATUS  = 8'h40;
	localparam logic [7:0] ADDR_EVT_MASK    = 8'h41;
	localparam logic [7:0] ADDR_CORE_STATUS = 8'h42;
	localparam logic [7:0] ADDR_CMD_STATUS  = 8'h43;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int INIT_SELECT_BIT = 4;
	localparam int SEL_HI_BIT      = 4;
	localparam int SEL_LO_BIT      = 3;
	localparam int MODE_SPECIAL_NESTING_ENABLE_BIT   = 4;
	localparam int MODE_AUTO_EOI_ENABLE_BIT   = 1;
	localparam int CMD_HI_BIT      = 7;
	localparam int CMD_LO_BIT      = 5;
	localparam int VEC_HI_BIT      = 7;
	localparam int VEC_LO_BIT      = 3;
	localparam int LEVEL_HI_BIT    = 2;

	// Event status bits
	localparam int EVT_MASTER_INIT = 0;
	localparam int EVT_SLAVE_INIT  = 1;
	localparam int EVT_EOI_CMD     = 2;
	localparam int EVT_SPURIOUS    = 3;
	localparam int EVT_W           = 4;

	// ----------------------------------------
	// Reset values and fixed levels
	// ----------------------------------------
	localparam logic [7:0]       MASK_RESET     = 8'h00;
	localparam logic [2:0]       CAS_ID_RESET   = 3'h7;
	localparam logic [2:0]       PRIO_LOW_RESET = 3'h7;
	localparam logic [2:0]       CASCADE_LINE   = 3'h2;
	localparam logic [2:0]       SPURIOUS_LEVEL = 3'h7;
	localparam logic [EVT_W-1:0] EVT_RESET      = 4'h0;

	typedef enum logic [2:0] {
		CMD_ROT_AUTO_EOI_ENABLE_CLR = 3'b000,
		CMD_NONSPEC_EOI  = 3'b001,
		CMD_NOP          = 3'b010,
		CMD_SPEC_EOI     = 3'b011,
		CMD_ROT_AUTO_EOI_ENABLE_SET = 3'b100
	} eoi_cmd_t;

	localparam eoi_cmd_t CMD_RESET = CMD_NONSPEC_EOI;

	typedef enum logic [1:0] {
		INIT_READY        = 2'b00,
		INIT_WAIT_BASE    = 2'b01,
		INIT_WAIT_CASCADE = 2'b10,
		INIT_WAIT_MODE    = 2'b11
	} init_state_t;

	typedef enum logic [1:0] {
		ACK_IDLE    = 2'b00,
		ACK_FIRST   = 2'b01,
		ACK_BETWEEN = 2'b10,
		ACK_SECOND  = 2'b11
	} ack_state_t;

	typedef struct packed {
		logic       ready;
		logic [7:0] mask;
		logic [4:0] vec_base;
		logic [2:0] cas_id;
		logic       special_nesting_enable;
		logic       auto_eoi_enable;
		eoi_cmd_t   last_cmd;
	} ctl_cfg_t;

	typedef struct packed {
		logic       init_start;
		logic       init_done;
		logic       cmd_valid;
		eoi_cmd_t   cmd;
		logic [2:0] level;
	} ctl_evt_t;

endpackage

// [rtl/pic_ctl_regs.sv]
// Per-controller programming state: init word sequence, mask, mode, commands.
// Assumes write strobes are already decoded to this controller's even/odd port.
`timescale 1ns/1ns
`default_nettype none

module pic_ctl_regs (
	// Clock and reset
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	// Decoded writes
	input  wire logic                     wr_even,
	input  wire logic                     wr_odd,
	input  wire logic [7:0]               wdata,
	// Programmed state and one-cycle events
	output cascaded_pic_pkg::ctl_cfg_t    cfg,
	output cascaded_pic_pkg::ctl_evt_t    evt
);

	cascaded_pic_pkg::init_state_t state_q;
	cascaded_pic_pkg::ctl_cfg_t    cfg_q;
	cascaded_pic_pkg::ctl_evt_t    evt_q;
	logic                          start;

	// A start word is recognised in any state, so a stuck sequence can restart
	assign start = wr_even && wdata[cascaded_pic_pkg::INIT_SELECT_BIT];

	// ----------------------------------------
	// Init sequence and programmed words
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q        <= cascaded_pic_pkg::INIT_READY;
			cfg_q.ready    <= 1'b1;
			cfg_q.mask     <= cascaded_pic_pkg::MASK_RESET;
			cfg_q.vec_base <= 5'h00;
			cfg_q.cas_id   <= cascaded_pic_pkg::CAS_ID_RESET;
			cfg_q.special_nesting_enable     <= 1'b0;
			cfg_q.auto_eoi_enable     <= 1'b0;
			cfg_q.last_cmd <= cascaded_pic_pkg::CMD_RESET;
		end else if (start) begin
			state_q      <= cascaded_pic_pkg::INIT_WAIT_BASE;
			cfg_q.ready  <= 1'b0;
			cfg_q.mask   <= cascaded_pic_pkg::MASK_RESET;
			cfg_q.cas_id <= cascaded_pic_pkg::CAS_ID_RESET;
			cfg_q.special_nesting_enable   <= 1'b0;
			cfg_q.auto_eoi_enable   <= 1'b0;
		end else begin
			case (state_q)
				cascaded_pic_pkg::INIT_WAIT_BASE: begin
					if (wr_odd) begin
						cfg_q.vec_base <= wdata[cascaded_pic_pkg::VEC_HI_BIT:
							cascaded_pic_pkg::VEC_LO_BIT];
						state_q <= cascaded_pic_pkg::INIT_WAIT_CASCADE;
					end
				end
				cascaded_pic_pkg::INIT_WAIT_CASCADE: begin
					if (wr_odd) begin
						// Upper bits are expected zero and are not stored
						cfg_q.cas_id <= wdata[cascaded_pic_pkg::LEVEL_HI_BIT:0];
						state_q      <= cascaded_pic_pkg::INIT_WAIT_MODE;
					end
				end
				cascaded_pic_pkg::INIT_WAIT_MODE: begin
					if (wr_odd) begin
						// Buffered and processor-mode bits have no effect here
						cfg_q.special_nesting_enable  <= wdata[cascaded_pic_pkg::MODE_SPECIAL_NESTING_ENABLE_BIT];
						cfg_q.auto_eoi_enable  <= wdata[cascaded_pic_pkg::MODE_AUTO_EOI_ENABLE_BIT];
						cfg_q.ready <= 1'b1;
						state_q     <= cascaded_pic_pkg::INIT_READY;
					end
				end
				default: begin
					if (wr_odd) begin
						cfg_q.mask <= wdata;
					end
					if (wr_even && (wdata[cascaded_pic_pkg::SEL_HI_BIT:
						cascaded_pic_pkg::SEL_LO_BIT] == 2'b00)) begin
						cfg_q.last_cmd <= cascaded_pic_pkg::eoi_cmd_t'(
							wdata[cascaded_pic_pkg::CMD_HI_BIT:cascaded_pic_pkg::CMD_LO_BIT]);
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// One-cycle events
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			evt_q <= '0;
		end else begin
			evt_q.init_start <= start;
			evt_q.init_done  <= !start && wr_odd &&
				(state_q == cascaded_pic_pkg::INIT_WAIT_MODE);
			evt_q.cmd_valid  <= !start && wr_even && (state_q == cascaded_pic_pkg::INIT_READY)
				&& (wdata[cascaded_pic_pkg::SEL_HI_BIT:cascaded_pic_pkg::SEL_LO_BIT] == 2'b00);
			evt_q.cmd        <= cascaded_pic_pkg::eoi_cmd_t'(
				wdata[cascaded_pic_pkg::CMD_HI_BIT:cascaded_pic_pkg::CMD_LO_BIT]);
			evt_q.level      <= wdata[cascaded_pic_pkg::LEVEL_HI_BIT:0];
		end
	end

	assign cfg = cfg_q;
	assign evt = evt_q;

endmodule

`default_nettype wire

// [rtl/cascaded_pic.sv]
// Master/slave interrupt controller pair: register port, acknowledge cycle,
// in-service tracking, end-of-interrupt commands and an event interrupt.
// Assumes request pins and the acknowledge strobe are asynchronous to clk.
//
// How it works
// - Slave compares its 3-bit id with the code the master broadcasts.
// - On a broadcast code equal to its programmed id, with a slave request winning, the slave supplies the vector, not the master.
// - Mode bit 4 set enables special fully nested mode.
// - Mode bit 1 selects normal or automatic end-of-interrupt.
// - Mask bit one blocks its request line; zero accepts it again.
// - Mask reads all zeros after reset.
// - Masking master line two also blocks every slave request.
// - After reset or init: fully nested, non-specific EOI, no rotation.
// - Command 000 clears auto rotate, 001 non-specific, 010 nop, 011 specific.
// - Command field defaults to 001.
// - A start word begins base, cascade and mode words on the odd port.
// - Slave interrupt output drives master request line two.
//
// The strobed register port was decided locally.
`timescale 1ns/1ns
`default_nettype none

module cascaded_pic (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Register port
	input  wire logic [7:0]  addr,
	input  wire logic [7:0]  wdata,
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	output logic      [7:0]  rdata,
	// Request pins, lines 7:0 master and 15:8 slave
	input  wire logic [15:0] irq_in,
	// Processor interrupt and acknowledge
	output logic             cpu_intr,
	input  wire logic        intr_ack_strobe_n,
	output logic      [7:0]  vector_data,
	output logic             vector_oe,
	// Cascade code broadcast
	output logic      [2:0]  cas_code,
	output logic             cas_oe,
	// Event interrupt
	output logic             irq_out
);

	// ----------------------------------------
	// Priority helpers
	// ----------------------------------------
	// Highest-priority set bit: line after the lowest-priority one comes first
	function automatic logic [3:0] pick(input logic [7:0] v, input logic [2:0] low);
		logic [3:0] r;
		logic [2:0] c;
		r = 4'h0;
		for (int k = 7; k >= 0; k--) begin
			c = 3'(low + 3'(k) + 3'h1);
			if (v[c]) begin
				r = {1'b1, c};
			end
		end
		return r;
	endfunction

	function automatic logic [2:0] rank(input logic [2:0] lvl, input logic [2:0] low);
		return 3'(lvl - low - 3'h1);
	endfunction

	// Request beats in-service when nothing is in service or it ranks higher
	function automatic logic wins(input logic [3:0] req, input logic [3:0] isr,
		input logic [2:0] low);
		return req[3] && (!isr[3] || (rank(req[2:0], low) < rank(isr[2:0], low)));
	endfunction

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [15:0] irq_meta_q;
	logic [15:0] irq_s_q;
	logic        ack_meta_q;
	logic        ack_s_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_meta_q <= 16'h0000;
			irq_s_q    <= 16'h0000;
			ack_meta_q <= 1'b1;
			ack_s_q    <= 1'b1;
		end else begin
			irq_meta_q <= irq_in;
			irq_s_q    <= irq_meta_q;
			ack_meta_q <= intr_ack_strobe_n;
			ack_s_q    <= ack_meta_q;
		end
	end

	// ----------------------------------------
	// Register decode and controller state
	// ----------------------------------------
	cascaded_pic_pkg::ctl_cfg_t cfg [2];
	cascaded_pic_pkg::ctl_evt_t evt [2];

	pic_ctl_regs u_master (
		.clk     (clk),
		.rst_n   (rst_n),
		.wr_even (wr_en && (addr == cascaded_pic_pkg::ADDR_MASTER_EVEN)),
		.wr_odd  (wr_en && (addr == cascaded_pic_pkg::ADDR_MASTER_ODD)),
		.wdata   (wdata),
		.cfg     (cfg[0]),
		.evt     (evt[0])
	);

	pic_ctl_regs u_slave (
		.clk     (clk),
		.rst_n   (rst_n),
		.wr_even (wr_en && (addr == cascaded_pic_pkg::ADDR_SLAVE_EVEN)),
		.wr_odd  (wr_en && (addr == cascaded_pic_pkg::ADDR_SLAVE_ODD)),
		.wdata   (wdata),
		.cfg     (cfg[1]),
		.evt     (evt[1])
	);

	// ----------------------------------------
	// Request resolution
	// ----------------------------------------
	logic [1:0][7:0] isr_q;
	logic [1:0][7:0] isr_d;
	logic [1:0][2:0] prio_q;
	logic [1:0]      rot_q;
	logic [7:0]      req_s;
	logic [7:0]      irr_m;
	logic [7:0]      req_m;
	logic [7:0]      isr_cmp_m;
	logic [3:0]      top_s;
	logic [3:0]      top_m;
	logic            slave_int;
	logic            m_pend;

	always_comb begin
		req_s     = irq_s_q[15:8] & ~cfg[1].mask;
		top_s     = pick(req_s, prio_q[1]);
		slave_int = wins(top_s, pick(isr_q[1], prio_q[1]), prio_q[1]);
		// Slave output shares line two with its pin
		irr_m     = irq_s_q[7:0];
		irr_m[cascaded_pic_pkg::CASCADE_LINE] = irq_s_q[cascaded_pic_pkg::CASCADE_LINE]
			| slave_int;
		req_m     = irr_m & ~cfg[0].mask;
		// Nested mode lets a slave request through while line two is in service
		isr_cmp_m = isr_q[0];
		if (cfg[0].special_nesting_enable) begin
			isr_cmp_m[cascaded_pic_pkg::CASCADE_LINE] = 1'b0;
		end
		top_m     = pick(req_m, prio_q[0]);
		m_pend    = wins(top_m, pick(isr_cmp_m, prio_q[0]), prio_q[0]);
	end

	// ----------------------------------------
	// Acknowledge sequence
	// ----------------------------------------
	cascaded_pic_pkg::ack_state_t ack_q;
	logic       ack_act;
	logic       first_end;
	logic       second_end;
	logic       id_match;
	logic [2:0] m_lvl_q;
	logic [2:0] s_lvl_q;
	logic       s_sel_q;
	logic       spur_q;
	logic [2:0] cas_code_q;
	logic       cas_oe_q;
	logic [7:0] vector_q;
	logic       vector_oe_q;
	logic       cpu_intr_q;

	assign ack_act    = !ack_s_q;
	assign first_end  = (ack_q == cascaded_pic_pkg::ACK_FIRST) && !ack_act;
	assign second_end = (ack_q == cascaded_pic_pkg::ACK_SECOND) && !ack_act;
	// Slave checks its id against the code the master is about to broadcast
	assign id_match   = m_pend && (top_m[2:0] == cfg[1].cas_id);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ack_q <= cascaded_pic_pkg::ACK_IDLE;
		end else begin
			case (ack_q)
				cascaded_pic_pkg::ACK_IDLE: begin
					if (ack_act) begin
						ack_q <= cascaded_pic_pkg::ACK_FIRST;
					end
				end
				cascaded_pic_pkg::ACK_FIRST: begin
					if (!ack_act) begin
						ack_q <= cascaded_pic_pkg::ACK_BETWEEN;
					end
				end
				cascaded_pic_pkg::ACK_BETWEEN: begin
					if (ack_act) begin
						ack_q <= cascaded_pic_pkg::ACK_SECOND;
					end
				end
				default: begin
					if (!ack_act) begin
						ack_q <= cascaded_pic_pkg::ACK_IDLE;
					end
				end
			endcase
		end
	end

	// Winner is frozen at the trailing edge of the first pulse
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			m_lvl_q <= cascaded_pic_pkg::SPURIOUS_LEVEL;
			s_lvl_q <= 3'h0;
			s_sel_q <= 1'b0;
			spur_q  <= 1'b0;
		end else if (first_end) begin
			m_lvl_q <= m_pend ? top_m[2:0] : cascaded_pic_pkg::SPURIOUS_LEVEL;
			s_lvl_q <= top_s[2:0];
			s_sel_q <= id_match && slave_int;
			spur_q  <= !m_pend;
		end
	end

	// Broadcast stands from the first trailing edge to the second
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cas_code_q <= 3'h0;
			cas_oe_q   <= 1'b0;
		end else if (first_end) begin
			cas_code_q <= m_pend ? top_m[2:0] : cascaded_pic_pkg::SPURIOUS_LEVEL;
			cas_oe_q   <= 1'b1;
		end else if (second_end) begin
			cas_oe_q   <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			vector_q    <= 8'h00;
			vector_oe_q <= 1'b0;
		end else if ((ack_q == cascaded_pic_pkg::ACK_BETWEEN) && ack_act) begin
			vector_q    <= s_sel_q ? {cfg[1].vec_base, s_lvl_q}
				: {cfg[0].vec_base, m_lvl_q};
			vector_oe_q <= 1'b1;
		end else if (second_end) begin
			vector_oe_q <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cpu_intr_q <= 1'b0;
		end else begin
			cpu_intr_q <= m_pend;
		end
	end

	// ----------------------------------------
	// In-service, end-of-interrupt and rotation
	// ----------------------------------------
	logic [3:0] itop [2];

	always_comb begin
		for (int c = 0; c < 2; c++) begin
			isr_d[c] = isr_q[c];
			itop[c]  = pick(isr_q[c], prio_q[c]);
			if (evt[c].init_start) begin
				isr_d[c] = 8'h00;
			end else if (evt[c].cmd_valid) begin
				if (evt[c].cmd == cascaded_pic_pkg::CMD_NONSPEC_EOI) begin
					if (itop[c][3]) begin
						isr_d[c][itop[c][2:0]] = 1'b0;
					end
				end else if (evt[c].cmd == cascaded_pic_pkg::CMD_SPEC_EOI) begin
					isr_d[c][evt[c].level] = 1'b0;
				end
			end
		end
		// Automatic end clears what the cycle just served
		if (second_end && !spur_q && cfg[0].auto_eoi_enable) begin
			isr_d[0][m_lvl_q] = 1'b0;
		end
		if (second_end && s_sel_q && cfg[1].auto_eoi_enable) begin
			isr_d[1][s_lvl_q] = 1'b0;
		end
		// Setting last, so an acknowledge is never lost to a same-cycle clear
		if (first_end && m_pend) begin
			isr_d[0][top_m[2:0]] = 1'b1;
		end
		if (first_end && id_match && slave_int) begin
			isr_d[1][top_s[2:0]] = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			isr_q <= '0;
		end else begin
			isr_q <= isr_d;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rot_q  <= 2'b00;
			prio_q <= {cascaded_pic_pkg::PRIO_LOW_RESET, cascaded_pic_pkg::PRIO_LOW_RESET};
		end else begin
			for (int c = 0; c < 2; c++) begin
				if (evt[c].init_start) begin
					rot_q[c]  <= 1'b0;
					prio_q[c] <= cascaded_pic_pkg::PRIO_LOW_RESET;
				end else if (evt[c].cmd_valid) begin
					if (evt[c].cmd == cascaded_pic_pkg::CMD_ROT_AUTO_EOI_ENABLE_CLR) begin
						rot_q[c] <= 1'b0;
					end else if (evt[c].cmd == cascaded_pic_pkg::CMD_ROT_AUTO_EOI_ENABLE_SET) begin
						rot_q[c] <= 1'b1;
					end
				end
			end
			// Served line drops to lowest priority under auto rotation
			if (second_end && !spur_q && cfg[0].auto_eoi_enable && rot_q[0]) begin
				prio_q[0] <= m_lvl_q;
			end
			if (second_end && s_sel_q && cfg[1].auto_eoi_enable && rot_q[1]) begin
				prio_q[1] <= s_lvl_q;
			end
		end
	end

	// ----------------------------------------
	// Event status and interrupt
	// ----------------------------------------
	logic [cascaded_pic_pkg::EVT_W-1:0] evt_stat_q;
	logic [cascaded_pic_pkg::EVT_W-1:0] evt_mask_q;
	logic [cascaded_pic_pkg::EVT_W-1:0] evt_set;
	logic [cascaded_pic_pkg::EVT_W-1:0] evt_clr;

	always_comb begin
		evt_set = '0;
		evt_set[cascaded_pic_pkg::EVT_MASTER_INIT] = evt[0].init_done;
		evt_set[cascaded_pic_pkg::EVT_SLAVE_INIT]  = evt[1].init_done;
		evt_set[cascaded_pic_pkg::EVT_EOI_CMD]     = evt[0].cmd_valid || evt[1].cmd_valid;
		evt_set[cascaded_pic_pkg::EVT_SPURIOUS]    = first_end && !m_pend;
		evt_clr = '0;
		if (wr_en && (addr == cascaded_pic_pkg::ADDR_EVT_STATUS)) begin
			evt_clr = wdata[cascaded_pic_pkg::EVT_W-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			evt_stat_q <= cascaded_pic_pkg::EVT_RESET;
		end else begin
			evt_stat_q <= (evt_stat_q & ~evt_clr) | evt_set;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			evt_mask_q <= cascaded_pic_pkg::EVT_RESET;
		end else if (wr_en && (addr == cascaded_pic_pkg::ADDR_EVT_MASK)) begin
			evt_mask_q <= wdata[cascaded_pic_pkg::EVT_W-1:0];
		end
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	logic [7:0] rd_mux;
	logic [7:0] rdata_q;

	always_comb begin
		if (addr == cascaded_pic_pkg::ADDR_MASTER_EVEN) begin
			rd_mux = irr_m;
		end else if (addr == cascaded_pic_pkg::ADDR_MASTER_ODD) begin
			rd_mux = cfg[0].mask;
		end else if (addr == cascaded_pic_pkg::ADDR_SLAVE_EVEN) begin
			rd_mux = irq_s_q[15:8];
		end else if (addr == cascaded_pic_pkg::ADDR_SLAVE_ODD) begin
			rd_mux = cfg[1].mask;
		end else if (addr == cascaded_pic_pkg::ADDR_EVT_STATUS) begin
			rd_mux = {4'h0, evt_stat_q};
		end else if (addr == cascaded_pic_pkg::ADDR_EVT_MASK) begin
			rd_mux = {4'h0, evt_mask_q};
		end else if (addr == cascaded_pic_pkg::ADDR_CORE_STATUS) begin
			rd_mux = {cfg[0].ready, cfg[1].ready, rot_q, s_sel_q, cas_code_q};
		end else if (addr == cascaded_pic_pkg::ADDR_CMD_STATUS) begin
			rd_mux = {cfg[0].last_cmd, cfg[1].last_cmd, 2'b00};
		end else begin
			rd_mux = 8'h00;
		end
	end

	// Data stand only in the cycle after the read strobe
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rd_en ? rd_mux : 8'h00;
		end
	end

	assign rdata       = rdata_q;
	assign cpu_intr    = cpu_intr_q;
	assign vector_data = vector_q;
	assign vector_oe   = vector_oe_q;
	assign cas_code    = cas_code_q;
	assign cas_oe      = cas_oe_q;
	assign irq_out     = |(evt_stat_q & evt_mask_q);

endmodule

`default_nettype wire

// [sim/cascaded_pic_monitor.sv]
// Checker on the controller pair's top-level ports.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none

module cascaded_pic_monitor (
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	// Watched ports
	input wire logic        rd_en,
	input wire logic [7:0]  rdata,
	input wire logic [15:0] irq_in,
	input wire logic        cpu_intr,
	input wire logic        intr_ack_strobe_n,
	input wire logic        vector_oe,
	input wire logic [2:0]  cas_code,
	input wire logic        cas_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// ----
	// Assertions
	// ----
	rd_idle_a: assert property (!$past(rd_en) |-> rdata == 8'h00)
		else $error("read data outside read slot");
	rst_quiet_a: assert property ($rose(rst_n) |-> !cpu_intr && !cas_oe && !vector_oe)
		else $error("outputs busy after reset");
	code_start_a: assert property ($rose(cas_oe) |->
		$past(intr_ack_strobe_n) && $past(intr_ack_strobe_n, 2))
		else $error("broadcast before first pulse ended");
	vec_start_a: assert property ($rose(vector_oe) |->
		!$past(intr_ack_strobe_n) && !$past(intr_ack_strobe_n, 2))
		else $error("vector outside second pulse");
	vec_in_bcast_a: assert property (vector_oe |-> cas_oe)
		else $error("vector without broadcast");
	code_hold_a: assert property (cas_oe && $past(cas_oe) |-> $stable(cas_code))
		else $error("cascade code changed");
	end_together_a: assert property ($fell(cas_oe) |-> !vector_oe && $past(vector_oe))
		else $error("broadcast and vector end apart");
	idle_quiet_a: assert property ((irq_in == 16'h0000) [*4] |-> !cpu_intr)
		else $error("interrupt with no request");

	cover property ($rose(vector_oe) && cas_code == 3'h2);
	cover property ($rose(cpu_intr));
	cover property ($fell(cas_oe));
endmodule

bind cascaded_pic cascaded_pic_monitor i_cascaded_pic_monitor (.clk, .rst_n, .rd_en, .rdata,
	.irq_in, .cpu_intr, .intr_ack_strobe_n, .vector_oe, .cas_code, .cas_oe);
`default_nettype wire

// [sim/ack_host.sv]
// Processor side: two acknowledge pulses per request, vector taken late in pulse two.
// Assumes the pin idles high between sequences.
`timescale 1ns/1ns
`default_nettype none

module ack_host (
	// Clock and trigger
	input  wire logic       clk,
	input  wire logic       go,
	// Acknowledge pin and answer
	output logic            ack_n,
	input  wire logic [7:0] vec,
	input  wire logic       vec_oe,
	input  wire logic [2:0] code,
	output logic      [7:0] got,
	output logic      [2:0] got_code,
	output logic            done
);
	initial begin
		ack_n = 1'b1;
		done = 1'b0;
		got = 8'h00;
		got_code = 3'h0;
		forever begin
			@(posedge clk);
			while (!go) @(posedge clk);
			// Stale code from the last sequence must not pass a missing answer
			got <= 8'h00;
			got_code <= 3'h0;
			repeat (2) begin
				ack_n <= 1'b0;
				// Phases of six clocks clear the pin synchronisers
				repeat (6) @(posedge clk);
				if (vec_oe) begin
					got <= vec;
					got_code <= code;
				end
				ack_n <= 1'b1;
				repeat (6) @(posedge clk);
			end
			done <= 1'b1;
			@(posedge clk);
			done <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// [sim/cascaded_pic_tb.sv]
// Self-checking bench for the controller pair: register port and acknowledge cycles.
// Assumes the ack_host partner and the bound port checker.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
	$display("BAD %s exp %h got %h", n, e, g); end end

module cascaded_pic_tb;
	logic        clk, rst_n, wr_en, rd_en, cpu_intr, intr_ack_strobe_n;
	logic        vector_oe, cas_oe, irq_out, go, done;
	logic [7:0]  addr, wdata, rdata, vector_data, got;
	logic [15:0] irq_in;
	logic [2:0]  cas_code, got_code;
	int          err_total, compares;

	cascaded_pic i_cascaded_pic (.clk, .rst_n, .addr, .wdata, .wr_en, .rd_en, .rdata, .irq_in,
		.cpu_intr, .intr_ack_strobe_n, .vector_data, .vector_oe, .cas_code, .cas_oe, .irq_out);
	ack_host i_ack_host (.clk, .go, .ack_n(intr_ack_strobe_n), .vec(vector_data),
		.vec_oe(vector_oe), .code(cas_code), .got, .got_code, .done);

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ----
	// Bus and wait tasks
	// ----
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [7:0] e, input string n);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 `CHK(n, e, rdata)
	endtask

	task wait_intr(input logic v);
		for (int i = 0; i < 20 && cpu_intr !== v; i++) @(posedge clk);
		`CHK("cpu_intr", v, cpu_intr)
		if (cpu_intr !== v) end_sim();
	endtask

	task ack(input logic [7:0] ev, input logic [2:0] ec);
		int i;
		@(posedge clk);
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		for (i = 0; i < 60 && done !== 1'b1; i++) @(posedge clk);
		if (done !== 1'b1) begin
			err_total++;
			end_sim();
		end
		`CHK("vector", ev, got)
		`CHK("cas_code", ec, got_code)
	endtask

	task end_sim;
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ----
	// Tests
	// ----
	initial begin
		{rst_n, wr_en, rd_en, go} <= 4'h0;
		{addr, wdata, irq_in} <= 32'h0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rd(8'h21, 8'h00, "m_mask");
		rd(8'hA1, 8'h00, "s_mask");
		rd(8'h43, 8'h24, "last_cmd");
		rd(8'h55, 8'h00, "unmapped");
		$display("test reset done");
		wr(8'h41, 8'h0F);
		wr(8'h20, 8'h11);
		wr(8'h21, 8'h08);
		wr(8'h21, 8'h04);
		wr(8'h21, 8'h01);
		wr(8'hA0, 8'h11);
		wr(8'hA1, 8'h70);
		wr(8'hA1, 8'h02);
		wr(8'hA1, 8'h01);
		rd(8'h40, 8'h03, "evt_status");
		`CHK("irq_out", 1'b1, irq_out)
		wr(8'h40, 8'h03);
		#1 `CHK("irq_out", 1'b0, irq_out)
		wr(8'h21, 8'hA5);
		rd(8'h21, 8'hA5, "m_mask");
		wr(8'h21, 8'h00);
		$display("test init done");
		irq_in <= 16'h0008;
		wait_intr(1'b1);
		ack(8'h0B, 3'h3);
		repeat (6) @(posedge clk);
		`CHK("cpu_intr", 1'b0, cpu_intr)
		wr(8'h20, 8'h20);
		wait_intr(1'b1);
		wr(8'h21, 8'h08);
		wait_intr(1'b0);
		irq_in <= 16'h0000;
		wr(8'h21, 8'h00);
		for (int c = 0; c < 4; c++) begin
			wr(8'h20, {c[2:0], 5'h00});
			rd(8'h43, {c[2:0], 5'h04}, "last_cmd");
		end
		wr(8'h20, 8'h48);
		rd(8'h43, 8'h64, "last_cmd");
		$display("test master done");
		irq_in <= 16'h0400;
		wait_intr(1'b1);
		ack(8'h72, 3'h2);
		wr(8'hA0, 8'h20);
		wr(8'h20, 8'h20);
		wait_intr(1'b1);
		wr(8'h21, 8'h04);
		wait_intr(1'b0);
		irq_in <= 16'h0000;
		wr(8'h21, 8'h00);
		$display("test slave done");
		wr(8'h20, 8'h11);
		wr(8'h21, 8'h08);
		wr(8'h21, 8'h04);
		wr(8'h21, 8'h03);
		irq_in <= 16'h0008;
		wait_intr(1'b1);
		ack(8'h0B, 3'h3);
		wait_intr(1'b1);
		irq_in <= 16'h0000;
		wait_intr(1'b0);
		wr(8'h40, 8'h0F);
		ack(8'h0F, 3'h7);
		rd(8'h40, 8'h08, "evt_status");
		$display("test auto eoi done");
		end_sim();
	end
endmodule
`default_nettype wire
